// ### core/lsi_line_status.sv
/*
 * Line status flags, receive/transmit character buffers, per-character error
 * tags on the receive buffer only, break detection, receive timeout and prioritised interrupt
 * identification with read freeze.
 * Assumes an external receiver and transmitter shift engine on the same clock,
 * a register port with one-cycle strobes, and modem delta logic elsewhere.
 */
// The implementer's own choices: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module lsi_line_status #(
    parameter int DEPTH = 16,
    parameter logic [15:0] BIT_CYCLES = 16'h0364
) (
    input wire logic ref_clk_i,                 // 100 MHz clock
    input wire logic nrst_i,                    // Async reset, active low
    input wire logic [2:0] addr_i,              // Register index
    input wire logic [7:0] wdata_i,             // Write data
    input wire logic wr_i,                      // Write strobe
    input wire logic rd_i,                      // Read strobe
    output logic [7:0] rdata_o,                 // Read data, cycle after strobe
    input wire logic serial_in_i,               // Serial line level
    input wire logic [3:0] frame_bits_i,        // Bits per frame incl. start/stop
    input wire logic rx_char_done_i,            // Receiver finished a character
    input wire logic [7:0] rx_data_i,           // Received character
    input wire logic rx_parity_en_i,            // Parity checked
    input wire logic rx_even_i,                 // Even parity selected
    input wire logic rx_parity_bit_i,           // Received parity bit
    input wire logic rx_stop_bit_i,             // Sampled stop bit
    output logic rx_resume_ok_o,                // Receiver may hunt for start
    input wire logic tx_shift_load_i,           // Shifter takes head character
    input wire logic tx_shift_empty_i,          // Shifter idle
    output logic [7:0] tx_data_o,               // Head transmit character
    output logic tx_avail_o,                    // Transmit character waiting
    input wire logic modem_delta_i,             // Any modem delta pending
    input wire logic [7:0] modem_status_i,      // Modem status byte
    output logic modem_read_o,                  // Modem status being read
    output logic int_pending_o                  // Interrupt pending, active high
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
    localparam logic [lsi_pkg::CNT_W-1:0] HALF_BIT =
        lsi_pkg::CNT_W'((32'(BIT_CYCLES) + 1) / lsi_pkg::RESUME_HALF_DIV);

    // Register decode
    wire rd_data = rd_i && addr_i == lsi_pkg::REG_DATA;
    wire wr_data = wr_i && addr_i == lsi_pkg::REG_DATA;
    wire wr_ier = wr_i && addr_i == lsi_pkg::REG_INTEN;
    wire rd_iir = rd_i && addr_i == lsi_pkg::REG_IDENT;
    wire wr_fcr = wr_i && addr_i == lsi_pkg::REG_IDENT;
    wire rd_lsr = rd_i && addr_i == lsi_pkg::REG_LINE;
    wire wr_lsr = wr_i && addr_i == lsi_pkg::REG_LINE;
    assign modem_read_o = rd_i && addr_i == lsi_pkg::REG_MODEM;

    // Control registers
    logic fifo_mode_r;
    logic [3:0] ier_r;
    logic [1:0] trig_r;
    wire mode_chg = wr_fcr && wdata_i[lsi_pkg::FC_EN] != fifo_mode_r;
    // Other control bits only take effect with the enable bit written as one
    wire fcr_live = wr_fcr && wdata_i[lsi_pkg::FC_EN];
    wire rx_clr = mode_chg || (fcr_live && wdata_i[lsi_pkg::FC_RXCLR]);
    wire tx_clr = mode_chg || (fcr_live && wdata_i[lsi_pkg::FC_TXCLR]);
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            fifo_mode_r <= 1'b0;
            ier_r <= lsi_pkg::IER_RST;
            trig_r <= lsi_pkg::TRIG_RST;
        end else begin
            if (wr_fcr) fifo_mode_r <= wdata_i[lsi_pkg::FC_EN];
            if (fcr_live) trig_r <= wdata_i[lsi_pkg::FC_TRIG +: 2];
            if (wr_ier) ier_r <= wdata_i[3:0];
        end
    end

    // Character time and derived spans
    wire [lsi_pkg::CNT_W-1:0] char_cyc =
        lsi_pkg::CNT_W'(frame_bits_i) * lsi_pkg::CNT_W'(BIT_CYCLES);
    wire [lsi_pkg::CNT_W-1:0] tout_cyc =
        lsi_pkg::CNT_W'(char_cyc * lsi_pkg::CNT_W'(lsi_pkg::TIMEOUT_CHARS));
    wire [lsi_pkg::CNT_W-1:0] tx_holding_empty_dly_cyc = char_cyc - lsi_pkg::CNT_W'(BIT_CYCLES);

    // Break detector
    lsi_pkg::lsi_brk_t brk_st_r, brk_st_nxt;
    logic [lsi_pkg::CNT_W-1:0] line_cnt_r, line_cnt_nxt;
    logic brk_evt;
    always_comb begin
        brk_st_nxt = brk_st_r;
        line_cnt_nxt = line_cnt_r;
        brk_evt = 1'b0;
        unique case (brk_st_r)
            lsi_pkg::BRK_IDLE: begin
                line_cnt_nxt = lsi_pkg::CNT_W'(1);
                if (!serial_in_i) brk_st_nxt = lsi_pkg::BRK_LOW;
            end
            lsi_pkg::BRK_LOW: begin
                line_cnt_nxt = line_cnt_r + lsi_pkg::CNT_W'(1);
                if (serial_in_i) begin
                    brk_st_nxt = lsi_pkg::BRK_IDLE;
                end else if (line_cnt_r >= char_cyc) begin
                    brk_evt = 1'b1;
                    brk_st_nxt = lsi_pkg::BRK_HOLD;
                    line_cnt_nxt = '0;
                end
            end
            lsi_pkg::BRK_HOLD: begin
                // Receiver stays parked until the line idles half a bit
                line_cnt_nxt = serial_in_i ? line_cnt_r + lsi_pkg::CNT_W'(1) : '0;
                if (serial_in_i && line_cnt_nxt >= HALF_BIT) begin
                    brk_st_nxt = lsi_pkg::BRK_IDLE;
                end
            end
        endcase
    end
    assign rx_resume_ok_o = brk_st_r != lsi_pkg::BRK_HOLD;
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            brk_st_r <= lsi_pkg::BRK_IDLE;
            line_cnt_r <= '0;
        end else begin
            brk_st_r <= brk_st_nxt;
            line_cnt_r <= line_cnt_nxt;
        end
    end

    // Receive buffer: tag bits {break, bad stop, parity} above the data byte
    logic [10:0] rx_mem [DEPTH];
    logic [AW-1:0] rx_rd_r, rx_wr_r;
    logic [AW:0] rx_cnt_r, rx_cnt_nxt;
    wire rx_par_bad = rx_parity_en_i && (^rx_data_i ^ rx_parity_bit_i ^ ~rx_even_i);
    wire rx_push = brk_evt || rx_char_done_i;
    wire [10:0] push_word = brk_evt ? 11'h400 : {1'b0, ~rx_stop_bit_i, rx_par_bad, rx_data_i};
    wire rx_full = fifo_mode_r ? rx_cnt_r == FULL_CNT : rx_cnt_r != '0;
    wire [10:0] rx_head = rx_mem[rx_rd_r];
    wire rx_pop = rd_data && rx_cnt_r != '0;
    // Character mode overwrites the single entry; a full FIFO drops it
    wire rx_take = rx_push && (!fifo_mode_r || !rx_full);
    wire overrun = rx_push && rx_full && !(rx_pop && !fifo_mode_r);
    wire [AW-1:0] rx_wr_idx = fifo_mode_r ? rx_wr_r : rx_rd_r;
    always_comb begin
        if (rx_clr) begin
            rx_cnt_nxt = '0;
        end else if (fifo_mode_r) begin
            rx_cnt_nxt = rx_cnt_r + (AW+1)'(rx_take) - (AW+1)'(rx_pop);
        end else begin
            rx_cnt_nxt = rx_take ? (AW+1)'(1) : rx_pop ? '0 : rx_cnt_r;
        end
    end
    // New head in FIFO mode: push into empty, or pop with more behind
    wire head_load = fifo_mode_r && ((rx_pop && rx_cnt_r > (AW+1)'(1)) ||
                     (rx_take && rx_cnt_nxt == (AW+1)'(1)));
    logic head_new_r;
    always_ff @(posedge ref_clk_i) begin
        if (rx_take) rx_mem[rx_wr_idx] <= push_word;
    end
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rx_rd_r <= '0;
            rx_wr_r <= '0;
            rx_cnt_r <= '0;
            head_new_r <= 1'b0;
        end else begin
            rx_cnt_r <= rx_cnt_nxt;
            head_new_r <= head_load && !rx_clr;
            if (rx_clr) begin
                rx_rd_r <= '0;
                rx_wr_r <= '0;
            end else if (fifo_mode_r) begin
                if (rx_pop) rx_rd_r <= rx_rd_r + AW'(1);
                if (rx_take) rx_wr_r <= rx_wr_r + AW'(1);
            end
        end
    end

    // Count of tagged entries still in the FIFO
    logic [AW:0] err_cnt_r, err_cnt_nxt;
    wire push_err = fifo_mode_r && rx_take && |push_word[10:8];
    wire pop_err = fifo_mode_r && rx_pop && |rx_head[10:8];
    assign err_cnt_nxt = rx_clr ? '0 : err_cnt_r + (AW+1)'(push_err) - (AW+1)'(pop_err);

    // Receive timeout: restarted by any accepted push or pop, or while empty or in character mode
    logic [lsi_pkg::CNT_W-1:0] to_cnt_r;
    logic tout_r;
    wire to_idle = !fifo_mode_r || rx_cnt_r == '0 || rx_take || rx_pop;
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            to_cnt_r <= '0;
            tout_r <= 1'b0;
            err_cnt_r <= '0;
        end else begin
            err_cnt_r <= err_cnt_nxt;
            to_cnt_r <= to_idle ? '0 : to_cnt_r + lsi_pkg::CNT_W'(1);
            if (!to_idle && to_cnt_r + lsi_pkg::CNT_W'(1) >= tout_cyc) begin
                tout_r <= 1'b1;
            end else if (rx_pop || rx_clr) begin
                tout_r <= 1'b0;
            end
        end
    end

    // Transmit buffer
    logic [7:0] tx_mem [DEPTH];
    logic [AW-1:0] tx_rd_r, tx_wr_r;
    logic [AW:0] tx_cnt_r, tx_cnt_nxt;
    logic had_two_r;
    wire tx_full = fifo_mode_r ? tx_cnt_r == FULL_CNT : 1'b0;
    wire tx_take = wr_data && !tx_full;
    wire tx_pop = tx_shift_load_i && tx_cnt_r != '0;
    wire [AW-1:0] tx_wr_idx = fifo_mode_r ? tx_wr_r : tx_rd_r;
    always_comb begin
        if (tx_clr) begin
            tx_cnt_nxt = '0;
        end else if (fifo_mode_r) begin
            tx_cnt_nxt = tx_cnt_r + (AW+1)'(tx_take) - (AW+1)'(tx_pop);
        end else begin
            tx_cnt_nxt = tx_take ? (AW+1)'(1) : tx_pop ? '0 : tx_cnt_r;
        end
    end
    assign tx_data_o = tx_mem[tx_rd_r];
    assign tx_avail_o = tx_cnt_r != '0;
    wire tx_emptied = tx_cnt_r != '0 && tx_cnt_nxt == '0;
    always_ff @(posedge ref_clk_i) begin
        if (tx_take) tx_mem[tx_wr_idx] <= wdata_i;
    end
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tx_rd_r <= '0;
            tx_wr_r <= '0;
            tx_cnt_r <= '0;
            had_two_r <= 1'b0;
        end else begin
            tx_cnt_r <= tx_cnt_nxt;
            // Remembers two at once since the FIFO was last empty
            had_two_r <= tx_cnt_nxt == '0 ? 1'b0 : had_two_r || tx_cnt_nxt > (AW+1)'(1);
            if (tx_clr) begin
                tx_rd_r <= '0;
                tx_wr_r <= '0;
            end else if (fifo_mode_r) begin
                if (tx_pop) tx_rd_r <= tx_rd_r + AW'(1);
                if (tx_take) tx_wr_r <= tx_wr_r + AW'(1);
            end
        end
    end

    // Delayed holding-empty after a single-character burst
    logic [lsi_pkg::CNT_W-1:0] dly_cnt_r;
    logic dly_run_r;
    wire dly_start = fifo_mode_r && tx_emptied && !had_two_r && !tx_clr;
    wire dly_done = dly_run_r && dly_cnt_r <= lsi_pkg::CNT_W'(1);
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            dly_cnt_r <= '0;
            dly_run_r <= 1'b0;
        end else if (dly_start) begin
            dly_cnt_r <= tx_holding_empty_dly_cyc;
            dly_run_r <= 1'b1;
        end else if (tx_take || dly_done || tx_clr) begin
            dly_run_r <= 1'b0;
        end else if (dly_run_r) begin
            dly_cnt_r <= dly_cnt_r - lsi_pkg::CNT_W'(1);
        end
    end

    // Line condition flags: write as base, then clears, then sets
    logic dr_r, oe_r, pe_r, fe_r, bi_r, tx_holding_empty_r, tx_all_empty_r, err_sum_r;
    logic dr_nxt, oe_nxt, pe_nxt, fe_nxt, bi_nxt, tx_holding_empty_nxt, tx_all_empty_nxt;
    wire tx_holding_empty_set = (fifo_mode_r ? (tx_emptied && had_two_r) || dly_done
                     : tx_pop && tx_cnt_nxt == '0) || tx_clr;
    wire [2:0] tag_set = fifo_mode_r ? (head_new_r ? rx_head[10:8] : 3'h0)
                         : (rx_take ? push_word[10:8] : 3'h0);
    // A load cycle still shows the shifter idle, so it must not count as empty
    wire tx_idle = tx_cnt_nxt == '0 && tx_shift_empty_i && !tx_shift_load_i && !tx_take;
    always_comb begin
        dr_nxt = wr_lsr ? wdata_i[lsi_pkg::LS_DR] : dr_r;
        oe_nxt = wr_lsr ? wdata_i[lsi_pkg::LS_OE] : oe_r && !rd_lsr;
        pe_nxt = wr_lsr ? wdata_i[lsi_pkg::LS_PE] : pe_r && !rd_lsr;
        fe_nxt = wr_lsr ? wdata_i[lsi_pkg::LS_FE] : fe_r && !rd_lsr;
        bi_nxt = wr_lsr ? wdata_i[lsi_pkg::LS_BI] : bi_r && !rd_lsr;
        tx_holding_empty_nxt = wr_lsr ? wdata_i[lsi_pkg::LS_TX_HOLDING_EMPTY] : tx_holding_empty_r && !tx_take;
        tx_all_empty_nxt = wr_lsr ? wdata_i[lsi_pkg::LS_TX_ALL_EMPTY] : tx_all_empty_r && !tx_take;
        if (fifo_mode_r ? rx_cnt_nxt == '0 : rx_pop) dr_nxt = 1'b0;
        if (rx_take) dr_nxt = 1'b1;
        if (overrun) oe_nxt = 1'b1;
        if (tag_set[0]) pe_nxt = 1'b1;
        if (tag_set[1]) fe_nxt = 1'b1;
        if (tag_set[2]) bi_nxt = 1'b1;
        if (tx_holding_empty_set) tx_holding_empty_nxt = 1'b1;
        if (tx_idle) tx_all_empty_nxt = 1'b1;
    end
    wire [7:0] lsr_val = {err_sum_r, tx_all_empty_r, tx_holding_empty_r, bi_r, fe_r, pe_r, oe_r, dr_r};
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            {dr_r, oe_r, pe_r, fe_r, bi_r} <= 5'h00;
            tx_holding_empty_r <= 1'b1;
            tx_all_empty_r <= 1'b1;
            err_sum_r <= 1'b0;
        end else begin
            {dr_r, oe_r, pe_r, fe_r, bi_r} <= {dr_nxt, oe_nxt, pe_nxt, fe_nxt, bi_nxt};
            tx_holding_empty_r <= tx_holding_empty_nxt;
            tx_all_empty_r <= tx_all_empty_nxt;
            // Summary is not writable; a new tagged push beats the read clear
            if (!fifo_mode_r || rx_clr) err_sum_r <= 1'b0;
            else if (push_err) err_sum_r <= 1'b1;
            else if (rd_lsr && err_cnt_nxt == '0) err_sum_r <= 1'b0;
            else if (err_cnt_r != '0) err_sum_r <= 1'b1;
        end
    end

    // Interrupt classes and identification
    logic tx_holding_empty_int_r, frozen_r;
    logic [3:0] frz_id_r;
    wire [4:0] rx_lvl = trig_r == 2'h0 ? lsi_pkg::TRIG_L0 : trig_r == 2'h1 ? lsi_pkg::TRIG_L1 :
                        trig_r == 2'h2 ? lsi_pkg::TRIG_L2 : lsi_pkg::TRIG_L3;
    wire ls_act = ier_r[lsi_pkg::IE_LS] && (oe_r || pe_r || fe_r || bi_r);
    wire rda_act = ier_r[lsi_pkg::IE_RDA] &&
                   (fifo_mode_r ? 32'(rx_cnt_r) >= 32'(rx_lvl) : dr_r);
    wire to_act = ier_r[lsi_pkg::IE_RDA] && tout_r;
    wire tx_holding_empty_act = ier_r[lsi_pkg::IE_TX_HOLDING_EMPTY] && tx_holding_empty_int_r;
    wire ms_act = ier_r[lsi_pkg::IE_MS] && modem_delta_i;
    // Fixed ranking, line status first and modem last
    wire [3:0] live_id = ls_act ? lsi_pkg::ID_LS : rda_act ? lsi_pkg::ID_RDA :
                         to_act ? lsi_pkg::ID_TOUT : tx_holding_empty_act ? lsi_pkg::ID_TX_HOLDING_EMPTY :
                         ms_act ? lsi_pkg::ID_MS : lsi_pkg::ID_NONE;
    wire [3:0] shown_id = frozen_r ? frz_id_r : live_id;
    wire frz_alive = frz_id_r == lsi_pkg::ID_LS ? ls_act : frz_id_r == lsi_pkg::ID_RDA ? rda_act :
                     frz_id_r == lsi_pkg::ID_TOUT ? to_act : frz_id_r == lsi_pkg::ID_TX_HOLDING_EMPTY ?
                     tx_holding_empty_act : ms_act;
    wire tx_holding_empty_rise = tx_holding_empty_nxt && !tx_holding_empty_r;
    wire tx_holding_empty_en_rise = wr_ier && wdata_i[lsi_pkg::IE_TX_HOLDING_EMPTY] && !ier_r[lsi_pkg::IE_TX_HOLDING_EMPTY] && tx_holding_empty_r;
    wire tx_holding_empty_int_clr = tx_take || (rd_iir && shown_id == lsi_pkg::ID_TX_HOLDING_EMPTY);
    assign int_pending_o = !shown_id[0];
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tx_holding_empty_int_r <= 1'b0;
            frozen_r <= 1'b0;
            frz_id_r <= lsi_pkg::ID_NONE;
        end else begin
            // Set beats clear so an empty event on the clearing cycle survives
            if (tx_holding_empty_rise || mode_chg || tx_holding_empty_en_rise) tx_holding_empty_int_r <= 1'b1;
            else if (tx_holding_empty_int_clr) tx_holding_empty_int_r <= 1'b0;
            if (!frozen_r && rd_iir && live_id != lsi_pkg::ID_NONE) begin
                frozen_r <= 1'b1;
                frz_id_r <= live_id;
            end else if (frozen_r && !frz_alive) begin
                frozen_r <= 1'b0;
            end
        end
    end

    // Read data mux, zero outside the answer cycle
    wire [7:0] iir_val = {fifo_mode_r, fifo_mode_r, 2'b00, shown_id};
    wire [7:0] rd_mux = addr_i == lsi_pkg::REG_DATA ? rx_head[7:0] :
                        addr_i == lsi_pkg::REG_INTEN ? {4'h0, ier_r} :
                        addr_i == lsi_pkg::REG_IDENT ? iir_val :
                        addr_i == lsi_pkg::REG_LINE ? lsr_val :
                        addr_i == lsi_pkg::REG_MODEM ? modem_status_i : 8'h00;
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) rdata_o <= 8'h00;
        else rdata_o <= rd_i ? rd_mux : 8'h00;
    end
endmodule
`default_nettype wire

// ### core/lsi_pkg.sv
/*
 * Shared constants for the line status and interrupt identification block:
 * register offsets, field positions, identification codes, FIFO trigger levels,
 * break detector states and timing ratios.
 * Assumes a byte-wide register port with a 3-bit word index.
 */
package lsi_pkg;
    // Register indices on the plain register port
    localparam logic [2:0] REG_DATA = 3'h0;
    localparam logic [2:0] REG_INTEN = 3'h1;
    localparam logic [2:0] REG_IDENT = 3'h2;
    localparam logic [2:0] REG_LINE = 3'h5;
    localparam logic [2:0] REG_MODEM = 3'h6;
    // Line condition flag positions
    localparam int LS_DR = 0;
    localparam int LS_OE = 1;
    localparam int LS_PE = 2;
    localparam int LS_FE = 3;
    localparam int LS_BI = 4;
    localparam int LS_TX_HOLDING_EMPTY = 5;
    localparam int LS_TX_ALL_EMPTY = 6;
    localparam int LS_ERR = 7;
    // Interrupt enable positions
    localparam int IE_RDA = 0;
    localparam int IE_TX_HOLDING_EMPTY = 1;
    localparam int IE_LS = 2;
    localparam int IE_MS = 3;
    // FIFO control positions
    localparam int FC_EN = 0;
    localparam int FC_RXCLR = 1;
    localparam int FC_TXCLR = 2;
    localparam int FC_TRIG = 6;
    // Low nibble of the identification register
    localparam logic [3:0] ID_NONE = 4'h1;
    localparam logic [3:0] ID_LS = 4'h6;
    localparam logic [3:0] ID_RDA = 4'h4;
    localparam logic [3:0] ID_TOUT = 4'hc;
    localparam logic [3:0] ID_TX_HOLDING_EMPTY = 4'h2;
    localparam logic [3:0] ID_MS = 4'h0;
    // Receive FIFO trigger levels, selected by two control bits
    localparam logic [4:0] TRIG_L0 = 5'h01;
    localparam logic [4:0] TRIG_L1 = 5'h04;
    localparam logic [4:0] TRIG_L2 = 5'h08;
    localparam logic [4:0] TRIG_L3 = 5'h0e;
    // Reset values
    localparam logic [3:0] IER_RST = 4'h0;
    localparam logic [1:0] TRIG_RST = 2'h0;
    // Timing in character or bit units
    localparam int TIMEOUT_CHARS = 4;
    localparam int RESUME_HALF_DIV = 2;
    localparam int CNT_W = 24;
    // Break detector states
    typedef enum logic [2:0] {
        BRK_IDLE = 3'b001,
        BRK_LOW = 3'b010,
        BRK_HOLD = 3'b100
    } lsi_brk_t;
endpackage

// ### verif/lsi_line_status_monitor.sv
/* Port checker for the line status block.
   Assumes BIT_CYCLES of 16 and bind to every instance. */
`timescale 1ns/1ps
`default_nettype none
module lsi_line_status_monitor (
    input wire logic ref_clk_i,      // Clock
    input wire logic nrst_i,         // Reset, low
    input wire logic [2:0] addr_i,   // Index
    input wire logic [7:0] wdata_i,  // Wdata
    input wire logic wr_i,           // Write
    input wire logic rd_i,           // Read
    input wire logic [7:0] rdata_o,  // Rdata
    input wire logic serial_in_i,    // Line
    input wire logic rx_char_done_i, // Char in
    input wire logic rx_resume_ok_o, // Resume
    input wire logic [7:0] tx_data_o, // Head
    input wire logic tx_avail_o,     // Waiting
    input wire logic modem_read_o,   // Modem rd
    input wire logic int_pending_o   // Pending
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);
    // Quiet status reads: no new event can set a flag between them
    wire id_rd = rd_i && addr_i == lsi_pkg::REG_IDENT;
    wire ls_rd = rd_i && addr_i == lsi_pkg::REG_LINE && !rx_char_done_i && serial_in_i;
    // A push, break or data read one cycle earlier still tags the head late
    logic quiet_r;
    // Consecutive high line samples, saturating; keeps the unrolled property short
    logic [3:0] hi_cnt_r;
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            quiet_r <= 1'b0;
            hi_cnt_r <= 4'h0;
        end else begin
            quiet_r <= !rx_char_done_i && serial_in_i && !(rd_i && addr_i == lsi_pkg::REG_DATA);
            hi_cnt_r <= !serial_in_i ? 4'h0 : hi_cnt_r == 4'hf ? hi_cnt_r : hi_cnt_r + 4'h1;
        end
    end
    AST_ID_ZERO: assert property (id_rd |=> rdata_o[5:4] == 2'h0)
        else $error("ident bits 5:4 not zero");
    AST_ID_BIT0: assert property (id_rd |=> rdata_o[0] == !$past(int_pending_o))
        else $error("ident bit 0 disagrees with pending");
    AST_ID_CODE: assert property (id_rd |=>
        rdata_o[3:0] inside {4'h1, 4'h6, 4'h4, 4'hc, 4'h2, 4'h0})
        else $error("ident code unknown");
    AST_LS_CLEAR: assert property (ls_rd && quiet_r ##1
        !rx_char_done_i && !wr_i && serial_in_i ##1 ls_rd |=> rdata_o[4:1] == 4'h0)
        else $error("error flags survived status read");
    AST_RESUME_FALL: assert property ($fell(rx_resume_ok_o) |-> !$past(serial_in_i))
        else $error("resume dropped with line high");
    AST_RESUME_RISE: assert property ($rose(rx_resume_ok_o) |->
        $past(serial_in_i) && $past(serial_in_i, 7))
        else $error("resume before half bit high");
    AST_RESUME_BOUND: assert property (
        serial_in_i && hi_cnt_r >= 4'h9 |-> rx_resume_ok_o)
        else $error("resume late");
    AST_MODEM_RD: assert property (
        modem_read_o == (rd_i && addr_i == lsi_pkg::REG_MODEM))
        else $error("modem read strobe wrong");
    AST_TX_LOAD: assert property (
        wr_i && addr_i == lsi_pkg::REG_DATA && !tx_avail_o |=>
        tx_avail_o && tx_data_o == $past(wdata_i))
        else $error("write did not load holding");
endmodule
bind lsi_line_status lsi_line_status_monitor u_mon (.ref_clk_i, .nrst_i, .addr_i, .wdata_i, .wr_i,
    .rd_i, .rdata_o, .serial_in_i, .rx_char_done_i, .rx_resume_ok_o, .tx_data_o, .tx_avail_o,
    .modem_read_o, .int_pending_o);
`default_nettype wire

// ### verif/lsi_peer.sv
/* Far side: receiver engine handing characters, transmit shifter.
   Same clock as the block; shifter takes no character while run_i is low. */
`timescale 1ns/1ps
`default_nettype none
module lsi_peer #(parameter int SHIFT = 160) (
    input wire logic clk_i,      // Clock
    input wire logic nrst_i,     // Reset, low
    input wire logic run_i,      // Shifter may take
    input wire logic tx_avail_i, // Char waiting
    output logic tx_load_o,      // Take head
    output logic tx_empty_o,     // Shifter idle
    output var logic done_o,     // Char done
    output var logic [7:0] data_o, // Char
    output var logic par_o,      // Parity bit
    output var logic stop_o      // Stop bit
);
    logic [8:0] cnt_r;
    // Busy one frame per take; released lines show inverted junk
    assign tx_empty_o = cnt_r == 9'h000;
    assign tx_load_o = tx_empty_o && tx_avail_i && run_i;
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) cnt_r <= 9'h000;
        else if (tx_load_o) cnt_r <= SHIFT[8:0];
        else if (!tx_empty_o) cnt_r <= cnt_r - 9'h001;
    end
    initial {done_o, data_o, par_o, stop_o} = 11'h001;
    // One character; bad flips even parity
    task automatic send(input logic [7:0] d, input logic bad, input logic stop);
        @(posedge clk_i);
        {done_o, data_o, par_o, stop_o} <= {1'b1, d, ^d ^ bad, stop};
        @(posedge clk_i);
        {done_o, data_o, par_o, stop_o} <= {1'b0, ~d, ~(^d ^ bad), ~stop};
    endtask
endmodule
`default_nettype wire

// ### verif/tb_lsi_line_status.sv
/* Directed bench: register reads and writes with expected bytes.
   Uses lsi_peer at the far side and the bound port checker. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin bad_count++; \
    $display("Error %0t: got %h want %h", $time, a, b); end end
module tb_lsi_line_status;
    logic ref_clk_i = 1'b0, nrst_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, run = 1'b1;
    logic serial_in_i = 1'b1, modem_delta_i = 1'b0;
    logic [2:0] addr_i = 3'h0;
    logic [7:0] wdata_i = 8'h00;
    wire logic [7:0] rdata_o, tx_data_o, rxd;
    wire logic tx_avail, ld, emp, done, par, stp, irq, resume;
    int bad_count = 0;
    int compares = 0;
    always #5 ref_clk_i = ~ref_clk_i;
    lsi_peer peer (.clk_i(ref_clk_i), .nrst_i, .run_i(run), .tx_avail_i(tx_avail), .tx_load_o(ld),
        .tx_empty_o(emp), .done_o(done), .data_o(rxd), .par_o(par), .stop_o(stp));
    lsi_line_status #(.BIT_CYCLES(16'h0010)) dut (.ref_clk_i, .nrst_i, .addr_i, .wdata_i, .wr_i,
        .rd_i, .rdata_o, .serial_in_i, .frame_bits_i(4'ha), .rx_char_done_i(done), .rx_data_i(rxd),
        .rx_parity_en_i(1'b1), .rx_even_i(1'b1), .rx_parity_bit_i(par), .rx_stop_bit_i(stp),
        .rx_resume_ok_o(resume), .tx_shift_load_i(ld), .tx_shift_empty_i(emp), .tx_data_o,
        .tx_avail_o(tx_avail), .modem_delta_i, .modem_status_i(8'h3c), .modem_read_o(),
        .int_pending_o(irq));
    // One-cycle strobes; read data looked at mid-cycle after the strobe
    task automatic wr(input int a, input logic [7:0] d);
        @(posedge ref_clk_i);
        {wr_i, addr_i, wdata_i} <= {1'b1, 3'(a), d};
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input int a, input logic [7:0] e, input logic [7:0] m = 8'hff);
        @(posedge ref_clk_i);
        {rd_i, addr_i} <= {1'b1, 3'(a)};
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        @(negedge ref_clk_i);
        `CHK(rdata_o & m, e)
    endtask
    task automatic report_and_stop();
        $display("Compares %0d, mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Whole run is near 465 cycles
    initial begin
        #300000;
        bad_count++;
        report_and_stop();
    end
    initial begin
        repeat (16) @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        rd(5, 8'h60);
        rd(2, 8'h01);
        wr(1, 8'h05);
        peer.send(8'h5a, 1'b0, 1'b1);
        rd(5, 8'h61);
        rd(2, 8'h04);
        rd(0, 8'h5a);
        peer.send(8'h33, 1'b0, 1'b1);
        peer.send(8'hc4, 1'b1, 1'b1);
        rd(2, 8'h06);
        rd(5, 8'h67);
        rd(2, 8'h04);
        rd(0, 8'hc4);
        peer.send(8'h07, 1'b0, 1'b0);
        rd(5, 8'h69);
        rd(0, 8'h07);
        wr(5, 8'h9e);
        // Idle transmitter sets all-empty again at once
        rd(5, 8'h5e);
        wr(5, 8'h60);
        run <= 1'b0;
        wr(1, 8'h02);
        rd(2, 8'h02);
        rd(2, 8'h01);
        `CHK(irq, 1'b0)
        wr(0, 8'ha5);
        rd(5, 8'h00);
        `CHK(tx_data_o, 8'ha5)
        @(posedge ref_clk_i) run <= 1'b1;
        rd(5, 8'h20);
        repeat (170) @(posedge ref_clk_i);
        rd(5, 8'h60);
        wr(1, 8'h08);
        modem_delta_i <= 1'b1;
        rd(2, 8'h00);
        rd(6, 8'h3c);
        @(posedge ref_clk_i) modem_delta_i <= 1'b0;
        rd(2, 8'h01);
        wr(1, 8'h04);
        serial_in_i <= 1'b0;
        repeat (175) @(posedge ref_clk_i);
        serial_in_i <= 1'b1;
        rd(2, 8'h06);
        `CHK(irq, 1'b1)
        rd(5, 8'h10, 8'h10);
        `CHK(resume, 1'b0)
        repeat (12) @(posedge ref_clk_i);
        `CHK(resume, 1'b1)
        rd(0, 8'h00);
        wr(1, 8'h00);
        wr(2, 8'h01);
        rd(2, 8'hc1);
        peer.send(8'h11, 1'b0, 1'b1);
        peer.send(8'h22, 1'b1, 1'b1);
        rd(5, 8'he1);
        rd(0, 8'h11);
        rd(5, 8'he5);
        rd(0, 8'h22);
        rd(5, 8'h60, 8'h7f);
        rd(5, 8'h60);
        report_and_stop();
    end
endmodule
`default_nettype wire
